// ---- common/tcpu_pkg.sv ----
// Shared constants, register map and carrier types of the true-colour pixel unpacker.
// Assumes one 200 MHz clock domain; pixel pins arrive asynchronous to it.
package tcpu_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register bus
   localparam int          ADDR_W         = 8;        // AXI4-Lite address width
   localparam logic [7:0]  ADDR_FMT       = 8'h00;    // pixel_format_select
   localparam logic [7:0]  ADDR_PAGE      = 8'h04;    // Palette page
   localparam logic [7:0]  ADDR_MASK      = 8'h08;    // Palette read mask
   localparam logic [7:0]  ADDR_CTRL      = 8'h0c;    // Endian and DAC width control
   localparam logic [7:0]  ADDR_STAT      = 8'h10;    // Read-only status
   localparam logic [7:0]  FMT_RST        = 8'h2d;    // Format after reset (no true colour)
   localparam logic [7:0]  PAGE_RST       = 8'h00;
   localparam logic [7:0]  MASK_RST       = 8'hff;
   localparam logic [7:0]  CTRL_RST       = 8'h00;
   localparam int          CTRL_BIG_BIT   = 0;        // 1: big-endian pixel lines
   localparam int          CTRL_DAC8_BIT  = 1;        // 1: 8-bit DAC, 0: 6-bit DAC
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////
   // Format codes in bits 5..0 of pixel_format_select
   localparam logic [5:0]  CODE_555_SGL   = 6'h08;
   localparam logic [5:0]  CODE_565_SGL   = 6'h09;
   localparam logic [5:0]  CODE_555_DBL   = 6'h0a;
   localparam logic [5:0]  CODE_565_DBL   = 6'h0b;
   localparam logic [5:0]  CODE_888_HIGH  = 6'h0e;
   localparam logic [5:0]  CODE_888_LOW   = 6'h0d;

   typedef enum logic [2:0] {
      fmt_none,
      fmt_555_overlay_single,
      fmt_565_single,
      fmt_555_overlay_double,
      fmt_565_double,
      fmt_888_overlay_high,
      fmt_888_overlay_low
   } tcpu_fmt_type;

   ////////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } tcpu_rgb_type;

   typedef struct packed {
      tcpu_rgb_type colour;     // True-colour DAC words
      logic [7:0]   overlay;    // Unmasked overlay value
   } tcpu_pix_type;

   // Whole state of the top module
   typedef struct packed {
      logic [7:0]   fmt_q;
      logic [7:0]   page_q;
      logic [7:0]   mask_q;
      logic [7:0]   ctrl_q;
      logic         awready_q;
      logic         wready_q;
      logic         bvalid_q;
      logic [1:0]   bresp_q;
      logic         arready_q;
      logic         rvalid_q;
      logic [1:0]   rresp_q;
      logic [31:0]  rdata_q;
      logic [2:0]   sclk_s;
      logic [2:0]   pclk_s;
      logic [2:0]   blank_s;
      logic [2:0]   csync_s;
      logic         sclk_lvl;
      logic         pclk_lvl;
      logic         blank_lvl;
      logic         csync_lvl;
      logic [31:0]  data_s1;
      logic [31:0]  data_s2;
      logic [31:0]  data_s3;
      logic [31:0]  data_f;
      logic [31:0]  bus_q;      // Latched load, endian corrected
      logic         grp_q;      // 1: upper word is next
      tcpu_rgb_type rgb1_q;
      logic         ovl1_q;
      logic         blank1_q;
      logic         csync1_q;
      logic [7:0]   pal_addr_q;
      tcpu_rgb_type dac_q;
      logic         dac_blank_n_q;
      logic         dac_sync_n_q;
      logic         ovl_seen_q;
   } tcpu_state_type;

endpackage : tcpu_pkg

// ---- hdl/tcpu_field_unpack.sv ----
// Splits one selected pixel word into DAC colour words and an overlay value.
// Assumes the word is already endian corrected; 16-bit words sit in bits 15..0.
module tcpu_field_unpack (
   input  wire tcpu_pkg::tcpu_fmt_type fmt,
   input  wire logic [31:0]            word,
   input  wire logic [7:0]             page,
   output tcpu_pkg::tcpu_pix_type      pix
);

   ////////////////////////////////////////////////////////////////////////////////
   // Field routing per format
   always_comb begin
      pix = '0;
      case (fmt)
         tcpu_pkg::fmt_555_overlay_single,
         tcpu_pkg::fmt_555_overlay_double: begin
            // 5-bit fields left aligned, low bits zero; page fills overlay top
            pix.colour.red   = {word[14:10], 3'h0};
            pix.colour.green = {word[9:5], 3'h0};
            pix.colour.blue  = {word[4:0], 3'h0};
            pix.overlay      = {page[7:1], word[15]};
         end
         tcpu_pkg::fmt_565_single,
         tcpu_pkg::fmt_565_double: begin
            // No overlay in 5-6-5
            pix.colour.red   = {word[15:11], 3'h0};
            pix.colour.green = {word[10:5], 2'h0};
            pix.colour.blue  = {word[4:0], 3'h0};
            pix.overlay      = 8'h00;
         end
         tcpu_pkg::fmt_888_overlay_high: begin
            // Full 8-bit colours taken as given
            pix.overlay      = word[31:24];
            pix.colour.red   = word[23:16];
            pix.colour.green = word[15:8];
            pix.colour.blue  = word[7:0];
         end
         tcpu_pkg::fmt_888_overlay_low: begin
            pix.colour.blue  = word[31:24];
            pix.colour.green = word[23:16];
            pix.colour.red   = word[15:8];
            pix.overlay      = word[7:0];
         end
         default: begin
            pix = '0;
         end
      endcase
   end

endmodule : tcpu_field_unpack

// ---- hdl/tcpu_unpacker.sv ----
// True-colour pixel unpacker: pixel port capture, field split, overlay select, register slave.
// Assumes a palette that answers pal_data combinationally for pal_addr, and
// shift clock, pixel clock, blank, sync and pixel lines asynchronous to mclk.

module tcpu_unpacker (
   input  wire logic                        mclk,
   input  wire logic                        resetn,
   // AXI4-Lite slave
   input  wire logic [tcpu_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                        awvalid,
   output logic                             awready,
   input  wire logic [31:0]                 wdata,
   input  wire logic [3:0]                  wstrb,
   input  wire logic                        wvalid,
   output logic                             wready,
   output logic [1:0]                       bresp,
   output logic                             bvalid,
   input  wire logic                        bready,
   input  wire logic [tcpu_pkg::ADDR_W-1:0] araddr,
   input  wire logic                        arvalid,
   output logic                             arready,
   output logic [31:0]                      rdata,
   output logic [1:0]                       rresp,
   output logic                             rvalid,
   input  wire logic                        rready,
   // Frame buffer side
   input  wire logic [31:0]                 pixel_port_lines,
   input  wire logic                        shift_clk,
   input  wire logic                        pixel_clk,
   input  wire logic                        blank_n,
   input  wire logic                        sync_n,
   // Palette lookup
   output logic [7:0]                       pal_addr,
   input  wire tcpu_pkg::tcpu_rgb_type      pal_data,
   // DAC paths
   output tcpu_pkg::tcpu_rgb_type           dac,
   output logic                             dac_blank_n,
   output logic                             dac_sync_n
);

   tcpu_pkg::tcpu_state_type s;            // Registered state
   tcpu_pkg::tcpu_state_type d;            // Next state
   tcpu_pkg::tcpu_fmt_type   fmt_sel;      // Decoded format
   tcpu_pkg::tcpu_pix_type   pix;          // Split fields of selected word
   logic [31:0]              data_rev;     // Fully reversed pixel lines
   logic [31:0]              word_sel;     // Word being shifted out
   logic [7:0]               ovl_masked;   // Overlay after read mask
   logic                     sclk_tick;    // Filtered shift clock rise
   logic                     pclk_tick;    // Filtered pixel clock rise
   logic                     is_double;    // Two words per load
   logic                     dac8;         // 8-bit DAC width

   ////////////////////////////////////////////////////////////////////////////////
   // Bit reversal for big-endian lines
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_rev
         assign data_rev[gi] = s.data_f[31 - gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Field splitter
   tcpu_field_unpack u_unpack (
      .fmt  (fmt_sel),
      .word (word_sel),
      .page (s.page_q),
      .pix  (pix)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      d          = s;
      dac8       = s.ctrl_q[tcpu_pkg::CTRL_DAC8_BIT];
      // Format decode, bits 7 and 6 do not matter
      case (s.fmt_q[5:0])
         tcpu_pkg::CODE_555_SGL:  fmt_sel = tcpu_pkg::fmt_555_overlay_single;
         tcpu_pkg::CODE_565_SGL:  fmt_sel = tcpu_pkg::fmt_565_single;
         tcpu_pkg::CODE_555_DBL:  fmt_sel = tcpu_pkg::fmt_555_overlay_double;
         tcpu_pkg::CODE_565_DBL:  fmt_sel = tcpu_pkg::fmt_565_double;
         tcpu_pkg::CODE_888_HIGH: fmt_sel = tcpu_pkg::fmt_888_overlay_high;
         tcpu_pkg::CODE_888_LOW:  fmt_sel = tcpu_pkg::fmt_888_overlay_low;
         default:                 fmt_sel = tcpu_pkg::fmt_none;
      endcase
      is_double = (fmt_sel == tcpu_pkg::fmt_555_overlay_double) ||
                  (fmt_sel == tcpu_pkg::fmt_565_double);
      // Upper word only on the second pixel of a double load
      word_sel  = (is_double && s.grp_q) ? {16'h0000, s.bus_q[31:16]} : s.bus_q;

      // Three-stage pin synchronisers; a level counts once stages two and three agree
      d.sclk_s  = {s.sclk_s[1:0], shift_clk};
      d.pclk_s  = {s.pclk_s[1:0], pixel_clk};
      d.blank_s = {s.blank_s[1:0], blank_n};
      d.csync_s = {s.csync_s[1:0], sync_n};
      d.data_s1 = pixel_port_lines;
      d.data_s2 = s.data_s1;
      d.data_s3 = s.data_s2;
      if (s.sclk_s[1] == s.sclk_s[2]) begin
         d.sclk_lvl = s.sclk_s[2];
      end
      if (s.pclk_s[1] == s.pclk_s[2]) begin
         d.pclk_lvl = s.pclk_s[2];
      end
      if (s.blank_s[1] == s.blank_s[2]) begin
         d.blank_lvl = s.blank_s[2];
      end
      if (s.csync_s[1] == s.csync_s[2]) begin
         d.csync_lvl = s.csync_s[2];
      end
      if (s.data_s2 == s.data_s3) begin
         d.data_f = s.data_s3;
      end
      sclk_tick = d.sclk_lvl && !s.sclk_lvl;
      pclk_tick = d.pclk_lvl && !s.pclk_lvl;

      // Pixel clock shifts the next group out of the latched load
      ovl_masked = pix.overlay & s.mask_q;
      if (pclk_tick) begin
         if (fmt_sel == tcpu_pkg::fmt_none) begin
            d.rgb1_q = '0;
            d.ovl1_q = 1'b0;
         end else begin
            d.rgb1_q = pix.colour;
            d.ovl1_q = (ovl_masked != 8'h00);
         end
         d.pal_addr_q = ovl_masked;
         // Take the level that arrives with this pixel edge, not the one before it
         d.blank1_q   = d.blank_lvl;
         d.csync1_q   = d.csync_lvl;
         d.grp_q      = is_double && !s.grp_q;
      end
      // Shift clock latches every group at once; the low group goes first
      if (sclk_tick) begin
         d.bus_q = s.ctrl_q[tcpu_pkg::CTRL_BIG_BIT] ? data_rev : s.data_f;
         d.grp_q = 1'b0;
      end

      // Output stage: palette colour wins when overlay is live
      if (s.ovl1_q) begin
         if (dac8) begin
            d.dac_q = pal_data;
         end else begin
            d.dac_q.red   = {pal_data.red[5:0], 2'h0};
            d.dac_q.green = {pal_data.green[5:0], 2'h0};
            d.dac_q.blue  = {pal_data.blue[5:0], 2'h0};
         end
      end else begin
         d.dac_q = s.rgb1_q;
      end
      d.dac_blank_n_q = s.blank1_q;
      d.dac_sync_n_q  = s.csync1_q;
      d.ovl_seen_q    = s.ovl1_q;

      // Write channel: accept address and data together, then answer
      d.awready_q = 1'b0;
      d.wready_q  = 1'b0;
      if (s.awready_q) begin
         // Handshake edge: commit the write and raise the response
         d.bvalid_q = 1'b1;
         d.bresp_q  = tcpu_pkg::RESP_OKAY;
         case ({awaddr[tcpu_pkg::ADDR_W-1:2], 2'b00})
            tcpu_pkg::ADDR_FMT: begin
               if (wstrb[0]) d.fmt_q = wdata[7:0];
            end
            tcpu_pkg::ADDR_PAGE: begin
               if (wstrb[0]) d.page_q = wdata[7:0];
            end
            tcpu_pkg::ADDR_MASK: begin
               if (wstrb[0]) d.mask_q = wdata[7:0];
            end
            tcpu_pkg::ADDR_CTRL: begin
               if (wstrb[0]) d.ctrl_q = {6'h00, wdata[1:0]};
            end
            tcpu_pkg::ADDR_STAT: begin
               d.bresp_q = tcpu_pkg::RESP_OKAY;
            end
            default: begin
               d.bresp_q = tcpu_pkg::RESP_SLVERR;
            end
         endcase
      end else if (awvalid && wvalid && !s.bvalid_q) begin
         d.awready_q = 1'b1;
         d.wready_q  = 1'b1;
      end
      if (s.bvalid_q && bready) begin
         d.bvalid_q = 1'b0;
      end

      // Read channel: one-cycle ready, data on the next cycle
      d.arready_q = 1'b0;
      if (s.arready_q) begin
         d.rvalid_q = 1'b1;
         d.rresp_q  = tcpu_pkg::RESP_OKAY;
         d.rdata_q  = 32'h0000_0000;
         case ({araddr[tcpu_pkg::ADDR_W-1:2], 2'b00})
            tcpu_pkg::ADDR_FMT:  d.rdata_q[7:0] = s.fmt_q;
            tcpu_pkg::ADDR_PAGE: d.rdata_q[7:0] = s.page_q;
            tcpu_pkg::ADDR_MASK: d.rdata_q[7:0] = s.mask_q;
            tcpu_pkg::ADDR_CTRL: d.rdata_q[7:0] = s.ctrl_q;
            tcpu_pkg::ADDR_STAT: begin
               d.rdata_q[0] = (fmt_sel != tcpu_pkg::fmt_none);
               d.rdata_q[1] = s.ovl_seen_q;
               d.rdata_q[2] = s.grp_q;
            end
            default: begin
               d.rresp_q = tcpu_pkg::RESP_SLVERR;
            end
         endcase
      end else if (arvalid && !s.rvalid_q) begin
         d.arready_q = 1'b1;
      end
      if (s.rvalid_q && rready) begin
         d.rvalid_q = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s        <= '0;
         s.fmt_q  <= tcpu_pkg::FMT_RST;
         s.page_q <= tcpu_pkg::PAGE_RST;
         s.mask_q <= tcpu_pkg::MASK_RST;
         s.ctrl_q <= tcpu_pkg::CTRL_RST;
      end else begin
         s <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs straight from flops
   assign awready     = s.awready_q;
   assign wready      = s.wready_q;
   assign bvalid      = s.bvalid_q;
   assign bresp       = s.bresp_q;
   assign arready     = s.arready_q;
   assign rvalid      = s.rvalid_q;
   assign rresp       = s.rresp_q;
   assign rdata       = s.rdata_q;
   assign pal_addr    = s.pal_addr_q;
   assign dac         = s.dac_q;
   assign dac_blank_n = s.dac_blank_n_q;
   assign dac_sync_n  = s.dac_sync_n_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   a_fmt_top_ignored: assert property (
      (s.fmt_q[5:0] == tcpu_pkg::CODE_888_LOW) |-> (fmt_sel == tcpu_pkg::fmt_888_overlay_low))
      else $error("format bits 7..6 changed the decode");
   a_colour_pass_delay: assert property (
      (pclk_tick && fmt_sel != tcpu_pkg::fmt_none && ovl_masked == 8'h00)
      |-> ##2 (s.dac_q == $past(pix.colour, 2)))
      else $error("true colour not passed after two cycles");
   a_overlay_lookup: assert property (
      (pclk_tick && fmt_sel != tcpu_pkg::fmt_none && ovl_masked != 8'h00 && dac8)
      |=> (s.pal_addr_q == $past(ovl_masked)) ##1 (s.dac_q == $past(pal_data)))
      else $error("palette colour did not replace true colour");
   a_blank_aligned: assert property (
      pclk_tick |-> ##2 (dac_blank_n == $past(s.blank_lvl)))
      else $error("blank not aligned with colour data");
   a_six_bit_pal: assert property (
      (s.ovl1_q && !dac8) |=> (s.dac_q.red[1:0] == 2'h0 && s.dac_q.blue[1:0] == 2'h0))
      else $error("6-bit palette data not applied");
   a_double_order: assert property (
      (pclk_tick && !sclk_tick && is_double && !s.grp_q) |=> s.grp_q ##0
      (word_sel[15:0] == s.bus_q[31:16]))
      else $error("second word not shifted after first");
   a_big_endian: assert property (
      (sclk_tick && s.ctrl_q[tcpu_pkg::CTRL_BIG_BIT])
      |=> (s.bus_q[0] == $past(s.data_f[31]) && s.bus_q[31] == $past(s.data_f[0])))
      else $error("big-endian lines not reversed");
   a_555_split: assert property (
      (pclk_tick && fmt_sel == tcpu_pkg::fmt_555_overlay_single)
      |=> (s.rgb1_q.red == {$past(s.bus_q[14:10]), 3'h0}) &&
          (s.pal_addr_q == ({$past(s.page_q[7:1]), $past(s.bus_q[15])} & $past(s.mask_q))))
      else $error("5-5-5 split or overlay address wrong");
   a_888_low_split: assert property (
      (pclk_tick && fmt_sel == tcpu_pkg::fmt_888_overlay_low)
      |=> (s.rgb1_q.blue == $past(s.bus_q[31:24]) && s.rgb1_q.red == $past(s.bus_q[15:8])))
      else $error("8-8-8 low field routing wrong");
   a_565_no_overlay: assert property (
      (pclk_tick && fmt_sel == tcpu_pkg::fmt_565_single) |=> (!s.ovl1_q && s.pal_addr_q == 8'h00))
      else $error("overlay active in 5-6-5");

endmodule : tcpu_unpacker

// ---- tb/tcpu_fb_model.sv ----
// Frame-buffer shift-register model that drives the pixel side of the unpacker.
// Assumes one bench process calls load and tick, one at a time, on mclk.
module tcpu_fb_model (
   input  wire logic        mclk,
   output logic [31:0]      lines,
   output logic             shift_clk,
   output logic             pixel_clk,
   output logic             blank_n,
   output logic             sync_n
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle levels; both clocks stand still between task calls
   initial begin
      lines = 32'h0;
      shift_clk = 1'b0;
      pixel_clk = 1'b0;
      blank_n = 1'b1;
      sync_n = 1'b1;
   end

   // One bus load: lines settle, shift clock rises, then the lines go to their inverse as it falls
   task automatic load(input logic [31:0] w);
      @(posedge mclk);
      lines <= w;
      repeat (5) @(posedge mclk);
      shift_clk <= 1'b1;
      repeat (8) @(posedge mclk);
      lines <= ~w;
      shift_clk <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask : load

   // One pixel-clock period; blank and sync are set up with its rising edge
   task automatic tick(input logic bl, input logic sy);
      @(posedge mclk);
      pixel_clk <= 1'b1;
      blank_n <= bl;
      sync_n <= sy;
      repeat (9) @(posedge mclk);
      pixel_clk <= 1'b0;
      repeat (9) @(posedge mclk);
   endtask : tick
endmodule : tcpu_fb_model

// ---- tb/testbench.sv ----
// Bench: registers over AXI4-Lite, pixel loads, DAC words against a model.
// Assumes tcpu_fb_model on the pixel side and a palette stand-in here.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                   mclk = 0, resetn = 0, awvalid = 0, wvalid = 0;
   logic                   bready = 0, arvalid = 0, rready = 0;
   logic [7:0]             awaddr = 0, araddr = 0, pal_addr, fmt, ctl, page, mask;
   logic [31:0]            wdata = 0, seed = 32'h06f37e3e, rdata, lines, word;
   logic [3:0]             wstrb = 0;
   logic                   awready, wready, bvalid, arready, rvalid, ovl_live;
   logic                   shift_clk, pixel_clk, blank_n, sync_n, dac_blank_n, dac_sync_n;
   logic [1:0]             bresp, rresp;
   tcpu_pkg::tcpu_rgb_type pal_data, dac;
   int                     miscompares = 0, samples_checked = 0, cyc = 0;
   logic [5:0]             codes [6] = '{6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0e, 6'h0d};

   always #2.5 mclk = ~mclk;
   // Palette stand-in, answers in the same cycle
   assign pal_data = {pal_addr ^ 8'ha5, ~pal_addr, pal_addr + 8'h3c};

   tcpu_unpacker i_dut (.mclk(mclk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .pixel_port_lines(lines), .shift_clk(shift_clk), .pixel_clk(pixel_clk),
      .blank_n(blank_n), .sync_n(sync_n), .pal_addr(pal_addr), .pal_data(pal_data),
      .dac(dac), .dac_blank_n(dac_blank_n), .dac_sync_n(dac_sync_n));
   tcpu_fb_model i_fb (.mclk(mclk), .lines(lines), .shift_clk(shift_clk),
      .pixel_clk(pixel_clk), .blank_n(blank_n), .sync_n(sync_n));

   ////////////////////////////////////////////////////////////////////////////////
   // Xorshift source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Expected DAC word for one pixel of the current load
   function automatic logic [23:0] exp_dac(input logic [31:0] wd, input bit hi);
      logic [31:0] w;
      logic [15:0] h;
      logic [7:0]  ov;
      logic [7:0]  a;
      logic [23:0] c;
      logic [23:0] p;
      for (int k = 0; k < 32; k++) w[k] = ctl[0] ? wd[31-k] : wd[k];
      h = (hi && fmt[1]) ? w[31:16] : w[15:0];
      ov = 8'h00;
      case (fmt[5:0])
         6'h08, 6'h0a: begin
            c = {h[14:10], 3'h0, h[9:5], 3'h0, h[4:0], 3'h0};
            ov = {page[7:1], h[15]};
         end
         6'h09, 6'h0b: c = {h[15:11], 3'h0, h[10:5], 2'h0, h[4:0], 3'h0};
         6'h0e: begin
            c = w[23:0];
            ov = w[31:24];
         end
         6'h0d: begin
            c = {w[15:8], w[23:16], w[31:24]};
            ov = w[7:0];
         end
         default: return 24'h0;
      endcase
      a = ov & mask;
      p = {a ^ 8'ha5, ~a, a + 8'h3c};
      if (!ctl[1]) p = {p[21:16], 2'h0, p[13:8], 2'h0, p[5:0], 2'h0};
      ovl_live = (a != 8'h00);
      return (a != 8'h00) ? p : c;
   endfunction : exp_dac

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite master
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk(bresp, er);
   endtask : axw

   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk(rdata, ed);
      chk(rresp, er);
   endtask : axr

   // One pixel tick with random blank and sync, then the DAC compare
   task automatic pix(input bit hi);
      logic [31:0] r;
      r = rnd();
      i_fb.tick(r[0], r[1]);
      chk(dac, exp_dac(word, hi));
      chk(dac_blank_n, r[0]);
      chk(dac_sync_n, r[1]);
   endtask : pix

   task automatic summarize();
      if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize

   // Hang guard
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         miscompares++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      chk(dac, 32'h0);
      axr(tcpu_pkg::ADDR_FMT, 32'h2d, tcpu_pkg::RESP_OKAY);
      axr(tcpu_pkg::ADDR_MASK, 32'hff, tcpu_pkg::RESP_OKAY);
      axr(tcpu_pkg::ADDR_PAGE, 32'h0, tcpu_pkg::RESP_OKAY);
      axr(tcpu_pkg::ADDR_CTRL, 32'h0, tcpu_pkg::RESP_OKAY);
      axr(8'h14, 32'h0, tcpu_pkg::RESP_SLVERR);
      axw(8'h14, 32'h5a, tcpu_pkg::RESP_SLVERR);
      axw(tcpu_pkg::ADDR_STAT, 32'hff, tcpu_pkg::RESP_OKAY);
      // Every format, both endian orders, both DAC widths, three mask kinds
      for (int i = 0; i < 6; i++) begin
         for (int v = 0; v < 4; v++) begin
            word = rnd();
            fmt = {word[7:6], codes[i]};
            ctl = 8'(v);
            page = word[15:8];
            mask = (v == 0) ? 8'h00 : (v == 3) ? word[23:16] : 8'hff;
            axw(tcpu_pkg::ADDR_FMT, {24'h0, fmt}, tcpu_pkg::RESP_OKAY);
            axw(tcpu_pkg::ADDR_CTRL, {24'h0, ctl}, tcpu_pkg::RESP_OKAY);
            axw(tcpu_pkg::ADDR_PAGE, {24'h0, page}, tcpu_pkg::RESP_OKAY);
            axw(tcpu_pkg::ADDR_MASK, {24'h0, mask}, tcpu_pkg::RESP_OKAY);
            axr(tcpu_pkg::ADDR_FMT, {24'h0, fmt}, tcpu_pkg::RESP_OKAY);
            word = rnd();
            i_fb.load(word);
            pix(1'b0);
            pix(1'b1);
            pix(1'b0);
            // Status: true colour on, overlay of the last pixel, upper word pending in the double formats only
            axr(tcpu_pkg::ADDR_STAT, {29'h0, fmt[1] & ~fmt[2], ovl_live, 1'b1},
               tcpu_pkg::RESP_OKAY);
         end
      end
      // Outside the true-colour formats the DAC stays at zero
      axw(tcpu_pkg::ADDR_FMT, 32'h2d, tcpu_pkg::RESP_OKAY);
      i_fb.load(rnd());
      i_fb.tick(1'b1, 1'b1);
      chk(dac, 32'h0);
      axr(tcpu_pkg::ADDR_STAT, 32'h0, tcpu_pkg::RESP_OKAY);
      summarize();
   end
endmodule : testbench
